// [verilog/fault_status_defines.svh]
// register offsets, field positions and reset values of the fault status block
`ifndef FAULT_STATUS_DEFINES_SVH
`define FAULT_STATUS_DEFINES_SVH
`define OFFSET_FAULT_LIVE 8'h3c
`define OFFSET_CONTROL 8'h80
`define OFFSET_SELECT 8'h84
`define OFFSET_IRQ_STATUS 8'h88
`define OFFSET_IRQ_MASK 8'h8c
`define BIT_RUNNING 31
`define BIT_ANY_ERR 28
`define BIT_HOLD 24
`define BIT_RESERVED_UNDEF 23
`define BIT_RESOLVER 22
`define BIT_COS_DISC 21
`define BIT_SINE_DISC 20
`define BIT_AMPLITUDE 18
`define BIT_DUAL_PATH 17
`define BIT_CONVERSION 16
`define PWR_HI 13
`define PWR_LO 8
`define GND_HI 5
`define GND_LO 0
`define CTRL_ENABLE 0
`define CTRL_CLEAR 1
`define CTRL_AMP_CLEAR 2
`define IRQ_HOLD 0
`define IRQ_SHORT_DONE 1
`define RESET_WORD 32'h00000000
`define RESET_SELECT 32'h00000000
`define RESET_IRQ 2'h0
`endif

// [verilog/fault_status_pkg.sv]
// types shared by the fault status block and its bus
package fault_status_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_type;
  typedef struct packed {
    logic resolverSignal;
    logic cosDisconnect;
    logic sineDisconnect;
    logic amplitude;
    logic dualPath;
    logic conversion;
  } fault_det_type;
  typedef struct packed {
    logic valid;
    logic [5:0] pwr;
    logic [5:0] gnd;
  } short_judge_type;
endpackage : fault_status_pkg

// [verilog/sticky_bits.sv]
// parameterised sticky flag bank, set wins over clear
`timescale 1ns/10ps
module sticky_bits #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] setBits,
  input wire logic [WIDTH-1:0] clrBits,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_reg;
  // hold each flag; a set in the clearing cycle keeps it high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= setBits | (flags_reg & ~clrBits);
    end
  end
  assign flags = flags_reg;
endmodule : sticky_bits

// [verilog/resolver_fault_status.sv]
// resolver channel fault status register bank on a classic wishbone slave
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "fault_status_defines.svh"
module resolver_fault_status (
  input wire logic clk,
  input wire logic rst_n,
  input wire fault_status_pkg::wb_req_type wbReq,
  output fault_status_pkg::wb_rsp_type wbRsp,
  input wire fault_status_pkg::fault_det_type faultDet,
  input wire logic shortDetectRunning,
  input wire fault_status_pkg::short_judge_type shortJudge,
  output logic amplitudeCountClear,
  output logic irq
);
  import fault_status_pkg::*;

  logic ack_reg;
  logic [31:0] rdData_reg;
  logic enable_reg;
  logic [31:0] select_reg;
  logic [1:0] irqMask_reg;
  logic running_reg;
  logic anyErr_reg;
  logic amp_reg;
  logic ampCountClear_reg;
  fault_det_type det_reg;
  logic busAccess;
  logic busWrite;
  logic wrControl;
  logic wrSelect;
  logic wrIrqStatus;
  logic wrIrqMask;
  logic clearPulse;
  logic ampClearPulse;
  logic convEnable;
  logic [5:0] pwrEnable;
  logic [5:0] gndEnable;
  logic [5:0] pwrFlags;
  logic [5:0] gndFlags;
  logic senseShort;
  logic convLive;
  logic anyDet;
  logic anyErr_next;
  logic holdFlag;
  logic holdRise;
  logic [1:0] irqStatus;
  logic [1:0] irqSet;
  logic [1:0] irqClr;
  logic [31:0] statusWord;
  logic [31:0] rdData_next;

  // bus strobes; a write acts only at the edge where ack is high
  assign busAccess = wbReq.cyc & wbReq.stb;
  assign busWrite = busAccess & wbReq.we & ack_reg;
  assign wrControl = busWrite & (wbReq.adr == `OFFSET_CONTROL) & wbReq.sel[0];
  assign wrSelect = busWrite & (wbReq.adr == `OFFSET_SELECT);
  assign wrIrqStatus = busWrite & (wbReq.adr == `OFFSET_IRQ_STATUS) & wbReq.sel[0];
  assign wrIrqMask = busWrite & (wbReq.adr == `OFFSET_IRQ_MASK) & wbReq.sel[0];
  assign clearPulse = wrControl & wbReq.dat[`CTRL_CLEAR];
  assign ampClearPulse = wrControl & wbReq.dat[`CTRL_AMP_CLEAR];

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= busAccess & ~ack_reg;
    end
  end

  // control register: detect enable bit, clear bits self-clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
    end else if (wrControl) begin
      enable_reg <= wbReq.dat[`CTRL_ENABLE];
    end
  end

  // fault select register, byte lanes honoured; a one suppresses the fault
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      select_reg <= `RESET_SELECT;
    end else if (wrSelect) begin
      for (int i = 0; i < 4; i++) begin
        if (wbReq.sel[i]) begin
          select_reg[8*i +: 8] <= wbReq.dat[8*i +: 8];
        end
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqMask_reg <= `RESET_IRQ;
    end else if (wrIrqMask) begin
      irqMask_reg <= wbReq.dat[1:0];
    end
  end

  // detector levels and running flag, sampled once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      det_reg <= '0;
      running_reg <= 1'b0;
    end else begin
      det_reg <= faultDet;
      running_reg <= shortDetectRunning;
    end
  end

  // per-fault enables from the select register
  assign convEnable = ~select_reg[`BIT_CONVERSION];
  assign pwrEnable = ~select_reg[`PWR_HI:`PWR_LO];
  assign gndEnable = ~select_reg[`GND_HI:`GND_LO];

  // short flags set by a run judging short, cleared by normal judgment or clear
  sticky_bits #(
    .WIDTH(12)
  ) shortFlagBank (
    .clk(clk),
    .rst_n(rst_n),
    .setBits({shortJudge.pwr & pwrEnable, shortJudge.gnd & gndEnable} &
             {12{shortJudge.valid}}),
    .clrBits(({~shortJudge.pwr, ~shortJudge.gnd} & {12{shortJudge.valid}}) |
             {12{clearPulse}}),
    .flags({pwrFlags, gndFlags})
  );

  // conversion flag: live conversion fault or any enabled sense pin short
  assign senseShort = (|pwrFlags[3:0]) | (|gndFlags[3:0]);
  assign convLive = (det_reg.conversion & convEnable) | senseShort;

  // amplitude flag set on fault, cleared by a clear only after recovery
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      amp_reg <= 1'b0;
    end else if (faultDet.amplitude & ~select_reg[`BIT_AMPLITUDE]) begin
      amp_reg <= 1'b1;
    end else if ((clearPulse | ampClearPulse) & ~faultDet.amplitude) begin
      amp_reg <= 1'b0;
    end
  end

  // count reset pulse to the amplitude detector on either clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ampCountClear_reg <= 1'b0;
    end else begin
      ampCountClear_reg <= clearPulse | ampClearPulse;
    end
  end
  assign amplitudeCountClear = ampCountClear_reg;

  // any enabled detection signal at its active level
  assign anyDet = (faultDet.resolverSignal & ~select_reg[`BIT_RESOLVER]) |
                  (faultDet.cosDisconnect & ~select_reg[`BIT_COS_DISC]) |
                  (faultDet.sineDisconnect & ~select_reg[`BIT_SINE_DISC]) |
                  (faultDet.amplitude & ~select_reg[`BIT_AMPLITUDE]) |
                  (faultDet.dualPath & ~select_reg[`BIT_DUAL_PATH]) |
                  (faultDet.conversion & convEnable) |
                  (|pwrFlags) | (|gndFlags);
  assign anyErr_next = enable_reg & anyDet;

  // live any-error flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      anyErr_reg <= 1'b0;
    end else begin
      anyErr_reg <= anyErr_next;
    end
  end

  // error hold: set wins, so a clear under a persisting fault keeps it
  sticky_bits #(
    .WIDTH(1)
  ) holdBank (
    .clk(clk),
    .rst_n(rst_n),
    .setBits(anyErr_next),
    .clrBits(clearPulse),
    .flags(holdFlag)
  );

  // interrupt events: hold rising and end of a short run
  assign holdRise = anyErr_next & ~holdFlag;
  assign irqSet = {shortJudge.valid, holdRise};
  assign irqClr = {2{wrIrqStatus}} & wbReq.dat[1:0];
  sticky_bits #(
    .WIDTH(2)
  ) irqBank (
    .clk(clk),
    .rst_n(rst_n),
    .setBits(irqSet),
    .clrBits(irqClr),
    .flags(irqStatus)
  );
  assign irq = |(irqStatus & irqMask_reg);

  // status word assembly; reserved bits read zero
  always_comb begin
    statusWord = `RESET_WORD;
    statusWord[`BIT_RUNNING] = running_reg;
    statusWord[`BIT_ANY_ERR] = anyErr_reg;
    statusWord[`BIT_HOLD] = holdFlag;
    statusWord[`BIT_RESERVED_UNDEF] = 1'b0;
    statusWord[`BIT_RESOLVER] = det_reg.resolverSignal & ~select_reg[`BIT_RESOLVER];
    statusWord[`BIT_COS_DISC] = det_reg.cosDisconnect & ~select_reg[`BIT_COS_DISC];
    statusWord[`BIT_SINE_DISC] = det_reg.sineDisconnect & ~select_reg[`BIT_SINE_DISC];
    statusWord[`BIT_AMPLITUDE] = amp_reg;
    statusWord[`BIT_DUAL_PATH] = det_reg.dualPath & ~select_reg[`BIT_DUAL_PATH];
    statusWord[`BIT_CONVERSION] = convLive;
    statusWord[`PWR_HI:`PWR_LO] = pwrFlags;
    statusWord[`GND_HI:`GND_LO] = gndFlags;
  end

  // read mux; full word returned whatever lanes are selected
  always_comb begin
    rdData_next = 32'h00000000;
    unique case (wbReq.adr)
      `OFFSET_FAULT_LIVE: rdData_next = statusWord;
      `OFFSET_CONTROL: rdData_next = {31'h0, enable_reg};
      `OFFSET_SELECT: rdData_next = select_reg;
      `OFFSET_IRQ_STATUS: rdData_next = {30'h0, irqStatus};
      `OFFSET_IRQ_MASK: rdData_next = {30'h0, irqMask_reg};
      default: rdData_next = 32'h00000000;
    endcase
  end

  // read data captured with the ack; reading changes no state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_reg <= 32'h00000000;
    end else if (busAccess & ~ack_reg & ~wbReq.we) begin
      rdData_reg <= rdData_next;
    end
  end

  assign wbRsp.ack = ack_reg;
  assign wbRsp.dat = rdData_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ACK_ONE_CYCLE: assert property (
    busAccess && !ack_reg |=> ack_reg ##1 !ack_reg)
    else $error("ack not a single cycle one after request");

  AST_RUNNING_FOLLOWS: assert property (
    ##1 statusWord[`BIT_RUNNING] == $past(shortDetectRunning))
    else $error("running bit does not follow detector");

  AST_ANY_ERR_GATED: assert property (
    !enable_reg |=> !statusWord[`BIT_ANY_ERR])
    else $error("any-error set while detection disabled");

  AST_ANY_ERR_FOLLOWS: assert property (
    enable_reg && anyDet |=> statusWord[`BIT_ANY_ERR])
    else $error("any-error missed an active fault");

  AST_HOLD_KEEPS: assert property (
    holdFlag && !clearPulse |=> holdFlag)
    else $error("hold bit dropped without clear");

  AST_HOLD_CLEAR_PERSIST: assert property (
    clearPulse && enable_reg && anyDet |=> statusWord[`BIT_HOLD])
    else $error("hold bit cleared under persisting fault");

  AST_HOLD_CLEARS: assert property (
    clearPulse && !anyErr_next |=> !holdFlag)
    else $error("hold bit not cleared by clear command");

  AST_RESOLVER_LIVE: assert property (
    faultDet.resolverSignal && !select_reg[`BIT_RESOLVER] && !wrSelect
    |=> statusWord[`BIT_RESOLVER])
    else $error("resolver fault bit not live");

  AST_AMP_SETS: assert property (
    faultDet.amplitude && !select_reg[`BIT_AMPLITUDE] |=> statusWord[`BIT_AMPLITUDE])
    else $error("amplitude bit not set on fault");

  AST_AMP_CLEARS: assert property (
    amp_reg && ampClearPulse && !faultDet.amplitude |=> !amp_reg ##0 amplitudeCountClear)
    else $error("amplitude bit or count not cleared");

  AST_SHORT_HOLDS: assert property (
    !shortJudge.valid && !clearPulse |=> $stable(pwrFlags) && $stable(gndFlags))
    else $error("short flag changed without run or clear");

  AST_CONV_SUPPRESSED: assert property (
    select_reg[`BIT_CONVERSION] && $stable(select_reg) && !senseShort
    |-> !statusWord[`BIT_CONVERSION])
    else $error("conversion bit set while suppressed");

  AST_SENSE_TO_CONV: assert property (
    senseShort |-> statusWord[`BIT_CONVERSION])
    else $error("sense short did not raise conversion bit");

  AST_DUAL_PATH_LIVE: assert property (
    faultDet.dualPath && !select_reg[`BIT_DUAL_PATH] && !wrSelect
    |=> statusWord[`BIT_DUAL_PATH])
    else $error("dual path fault bit not live");

  AST_RESOLVER_RECOVERS: assert property (
    !faultDet.resolverSignal |=> !statusWord[`BIT_RESOLVER])
    else $error("resolver fault bit stuck after recovery");

  AST_COS_DISC_LIVE: assert property (
    faultDet.cosDisconnect && !select_reg[`BIT_COS_DISC] && !wrSelect
    |=> statusWord[`BIT_COS_DISC])
    else $error("cosine disconnect bit not live");

  AST_ANY_ERR_DROPS: assert property (
    !anyDet |=> !statusWord[`BIT_ANY_ERR])
    else $error("any-error stayed set after recovery");

  AST_PWR_SHORT_JUDGED: assert property (
    shortJudge.valid |=> ((pwrFlags ^ $past(shortJudge.pwr)) & $past(pwrEnable)) == 6'h00)
    else $error("power short flags differ from run judgment");

  AST_GND_SHORT_JUDGED: assert property (
    shortJudge.valid |=> ((gndFlags ^ $past(shortJudge.gnd)) & $past(gndEnable)) == 6'h00)
    else $error("ground short flags differ from run judgment");

  AST_CONV_SELECT_OFF: assert property (
    select_reg[`BIT_CONVERSION] && !wrSelect && !senseShort && !shortJudge.valid
    |=> !statusWord[`BIT_CONVERSION])
    else $error("suppressed conversion fault reached its bit");

  AST_STATUS_WRITE_IGNORED: assert property (
    busWrite && wbReq.adr == `OFFSET_FAULT_LIVE
    |=> $stable(select_reg) && $stable(enable_reg) && $stable(irqMask_reg))
    else $error("write to status word changed a register");
endmodule : resolver_fault_status

// [verification/coil_model.sv]
// behavioural model of the resolver coils and the pin short detectors
`timescale 1ns/10ps
module coil_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire fault_status_pkg::fault_det_type faultCmd,
  input wire logic runReq,
  input wire logic [7:0] runLen,
  input wire logic [11:0] judgeCmd,
  input wire logic amplitudeCountClear,
  output fault_status_pkg::fault_det_type faultDet,
  output logic shortDetectRunning,
  output fault_status_pkg::short_judge_type shortJudge
);
  import fault_status_pkg::*;
  logic [7:0] runCnt_reg;
  logic [7:0] abnormalCnt_reg;
  // detector levels follow the commanded faults one cycle late
  always_ff @(posedge clk) begin
    faultDet <= rst_n ? faultCmd : '0;
  end
  // short run: judgments valid for one cycle at the end, scrambled otherwise
  always_ff @(posedge clk) begin
    shortJudge.valid <= 1'b0;
    {shortJudge.pwr, shortJudge.gnd} <= ~judgeCmd;
    if (!rst_n) begin
      runCnt_reg <= 8'h00;
    end else if (runReq) begin
      runCnt_reg <= runLen;
    end else if (runCnt_reg != 8'h00) begin
      runCnt_reg <= runCnt_reg - 8'h01;
      if (runCnt_reg == 8'h01) begin
        shortJudge.valid <= 1'b1;
        {shortJudge.pwr, shortJudge.gnd} <= judgeCmd;
      end
    end
  end
  assign shortDetectRunning = (runCnt_reg != 8'h00);
  // abnormal excitation count, restarted by the clear pulse
  always_ff @(posedge clk) begin
    if (!rst_n || amplitudeCountClear) begin
      abnormalCnt_reg <= 8'h00;
    end else begin
      abnormalCnt_reg <= abnormalCnt_reg + {7'h00, faultDet.amplitude};
    end
  end
endmodule : coil_model

// [verification/resolver_fault_status_test.sv]
// self-checking bench of the resolver fault status register bank
`timescale 1ns/10ps
module resolver_fault_status_test;
  import fault_status_pkg::*;
  localparam logic [31:0] M = 32'hff7fffff; // bit 23 is undefined
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wb_req_type wbReq = '0;
  wb_rsp_type wbRsp;
  fault_det_type faultCmd = '0;
  fault_det_type faultDet;
  short_judge_type shortJudge;
  logic shortDetectRunning;
  logic amplitudeCountClear;
  logic irq;
  logic irqA;
  logic runReq = 1'b0;
  logic [11:0] judgeCmd = 12'h000;
  logic [63:0] noteQ[$];
  logic [7:0] adrs[5] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h40};
  logic [5:0] r;
  logic held;
  int error_cnt = 0;
  int checks = 0;
  int pulseCnt = 0;
  int p;
  always #2.5 clk = ~clk;
  // design and coil model
  resolver_fault_status DUT (.clk(clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .faultDet(faultDet), .shortDetectRunning(shortDetectRunning), .shortJudge(shortJudge),
    .amplitudeCountClear(amplitudeCountClear), .irq(irq));
  coil_model coils (.clk(clk), .rst_n(rst_n), .faultCmd(faultCmd), .runReq(runReq),
    .runLen(8'h1e), .judgeCmd(judgeCmd), .amplitudeCountClear(amplitudeCountClear),
    .faultDet(faultDet), .shortDetectRunning(shortDetectRunning), .shortJudge(shortJudge));
  task automatic test_done();
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : compare_word
  task automatic compare_bit(input logic got, input logic exp);
    compare_word({31'h0, got}, {31'h0, exp});
  endtask : compare_bit
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
      input logic [31:0] dat);
    int n;
    @(posedge clk);
    wbReq <= '{1'b1, 1'b1, we, adr, sel, dat};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 20);
    wbReq <= '0;
    if (n >= 20) begin
      error_cnt++;
      test_done();
    end
  endtask : wb
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, 4'hf, dat);
  endtask : wr
  task automatic rd(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] m,
      input logic [31:0] e);
    noteQ.push_back({m, e});
    wb(1'b0, adr, sel, 32'h0);
  endtask : rd
  task automatic settle(input logic [5:0] f);
    faultCmd <= fault_det_type'(f);
    repeat (4) @(posedge clk);
  endtask : settle
  task automatic run(input logic [11:0] j);
    judgeCmd <= j;
    runReq <= 1'b1;
    @(posedge clk);
    runReq <= 1'b0;
  endtask : run
  // takes the oldest note whenever read data is acknowledged
  always @(posedge clk) begin
    if (wbRsp.ack === 1'b1 && wbReq.cyc === 1'b1 && wbReq.we === 1'b0) begin
      compare_word(wbRsp.dat & noteQ[0][63:32], noteQ[0][31:0]);
      void'(noteQ.pop_front());
    end
    if (amplitudeCountClear === 1'b1) begin
      pulseCnt++;
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'h90fc9050));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(8'h3c, 4'((1 << (1 << i)) - 1), M, 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      rd(adrs[i], 4'hf, 32'hffffffff, 32'h0);
    end
    settle(6'h20);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 4'hf, M, 32'h00400000);
    for (int i = 0; i < 8; i++) begin
      r = 6'($urandom) & 6'h3b;
      settle(r);
      rd(8'h3c, 4'hf, M, {9'h0, r[5:3], 2'h0, r[1:0], 16'h0});
    end
    settle(6'h00);
    wr(8'h80, 32'h1);
    held = 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = 6'($urandom) & 6'h3b;
      settle(r);
      held = held | (|r);
      rd(8'h3c, 4'hf, M, {3'h0, |r, 3'h0, held, 1'h0, r[5:3], 2'h0, r[1:0], 16'h0});
    end
    settle(6'h02);
    wr(8'h80, 32'h3);
    rd(8'h3c, 4'hf, M, 32'h11020000);
    settle(6'h00);
    wr(8'h80, 32'h3);
    rd(8'h3c, 4'hf, M, 32'h0);
    rd(8'h88, 4'hf, 32'h1, 32'h1);
    wr(8'h8c, 32'h0);
    @(posedge clk);
    irqA = irq;
    wr(8'h8c, 32'h3);
    @(posedge clk);
    compare_bit(irqA ^ irq, 1'b1);
    wr(8'h88, 32'h3);
    rd(8'h88, 4'hf, 32'h3, 32'h0);
    compare_bit(irq, 1'b0);
    for (int k = 0; k < 2; k++) begin
      settle(6'h04);
      rd(8'h3c, 4'hf, 32'h00040000, 32'h00040000);
      wr(8'h80, (k == 1) ? 32'h3 : 32'h5);
      rd(8'h3c, 4'hf, 32'h00040000, 32'h00040000);
      settle(6'h00);
      rd(8'h3c, 4'hf, 32'h00040000, 32'h00040000);
      p = pulseCnt;
      wr(8'h80, (k == 1) ? 32'h3 : 32'h5);
      repeat (3) @(posedge clk);
      compare_word(32'(pulseCnt - p), 32'h1);
      compare_word({24'h0, coils.abnormalCnt_reg}, 32'h0);
      rd(8'h3c, 4'hf, 32'h00040000, 32'h0);
    end
    wr(8'h80, 32'h3);
    run(12'h852);
    repeat (5) @(posedge clk);
    rd(8'h3c, 4'hf, 32'h80000000, 32'h80000000);
    repeat (40) @(posedge clk);
    rd(8'h3c, 4'hf, M, 32'h11012112);
    run(12'h800);
    repeat (45) @(posedge clk);
    rd(8'h3c, 4'hf, M, 32'h11002000);
    wr(8'h80, 32'h3);
    rd(8'h3c, 4'hf, 32'hfe7fffff, 32'h0);
    wr(8'h80, 32'h3);
    wr(8'h84, 32'h00010000);
    settle(6'h01);
    rd(8'h3c, 4'hf, 32'h11010000, 32'h0);
    wr(8'h84, 32'h0);
    repeat (3) @(posedge clk);
    rd(8'h3c, 4'hf, 32'h11010000, 32'h11010000);
    settle(6'h00);
    test_done();
  end
endmodule : resolver_fault_status_test
